/* verilog/sca_pkg.sv */
// Purpose : shared constants and types of the sideband configuration access slave
// Assumes : 200 MHz core clock, serial pins sampled through a three-stage synchroniser
// Notes   : every offset, code and reset value of the block is named here once
package sca_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // smbus command codes and fixed byte count
    localparam logic [7:0] SCA_CODE_SETUP   = 8'hBA;    // block write read setup
    localparam logic [7:0] SCA_CODE_BREAD   = 8'hBD;    // block read
    localparam logic [7:0] SCA_CODE_CALL    = 8'hCD;    // block write/read process call
    localparam logic [7:0] SCA_BYTE_COUNT   = 8'h04;    // four bytes each way
    localparam logic [7:0] SCA_IDLE_BYTE    = 8'hFF;    // sent past the last defined byte

    ////////////////////////////////////////////////////////////////////////////
    // command byte fields
    localparam logic [2:0] SCA_CMD_WRITE    = 3'h3;     // register write
    localparam logic [2:0] SCA_CMD_READ     = 3'h4;     // register read
    localparam logic [4:0] SCA_PORT_MAX     = 5'h05;    // highest legal port select
    localparam int         SCA_SMB_CMD_IDX  = 3;        // first command byte after count
    localparam int         SCA_I2C_CMD_IDX  = 1;        // first command byte, plain i2c
    localparam int         SCA_I2C_LAST     = 8;        // byte index of fourth data byte

    ////////////////////////////////////////////////////////////////////////////
    // slave address control register, upstream port, offset 344h
    localparam logic [11:0] SCA_CTRL_OFFSET = 12'h344;
    localparam logic [9:0]  SCA_CTRL_DWORD  = SCA_CTRL_OFFSET[11:2];
    localparam logic [4:0]  SCA_CTRL_PORT   = 5'h00;    // upstream port
    localparam logic [31:0] SCA_CTRL_RESET  = 32'h0000_0000;
    localparam logic [3:0]  SCA_ADDR_HIGH   = 4'hD;     // address bits 6:3 = 1101
    localparam logic [2:0]  SCA_BOOT_CYCLES = 3'h7;     // wait for strap synchroniser

    ////////////////////////////////////////////////////////////////////////////
    // packet error code
    localparam logic [7:0] SCA_PEC_POLY     = 8'h07;    // x^8 + x^2 + x + 1
    localparam logic [7:0] SCA_PEC_INIT     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // byte engine states and recognised protocols
    typedef enum logic [1:0] {SCA_IDLE, SCA_RX, SCA_TX} sca_mode_t;
    typedef enum logic [1:0] {SCA_P_I2C, SCA_P_SETUP, SCA_P_BREAD, SCA_P_CALL} sca_proto_t;

endpackage

/* verilog/sca_pin_sync.sv */
// Purpose : three-stage synchroniser with agreement filter for pin inputs
// Assumes : inputs are asynchronous to clk
// Notes   : output moves only when stages two and three agree
`timescale 1ns/10ps
module sca_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    ////////////////////////////////////////////////////////////////////////////
    // one filtered lane per input bit
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            logic s1;   // first stage, read only by s2
            logic s2;   // second stage
            logic s3;   // third stage
            // shift chain and agreement filter
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1   <= 1'b0;
                    s2   <= 1'b0;
                    s3   <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1 <= d[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        q[i] <= s3;
                    end
                end
            end
        end
    endgenerate

endmodule

/* verilog/sca_slave.sv */
// Purpose : serial slave giving an smbus or i2c master access to configuration registers
// Assumes : cfg_ack pulses once per cfg_req, with cfg_rdata valid on that cycle
// Notes   : the slave never stretches scl; bytes are handled at 200 MHz sampling
`timescale 1ns/10ps
module sca_slave (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic [2:0]  addr_strap,
    output logic             cfg_req,
    output logic             cfg_we,
    output logic [4:0]       cfg_port,
    output logic [3:0]       cfg_be,
    output logic [9:0]       cfg_addr,
    output logic [31:0]      cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_ack
);

    ////////////////////////////////////////////////////////////////////////////
    // state of the whole block
    typedef struct packed {
        sca_pkg::sca_mode_t  mode;    // byte engine state
        sca_pkg::sca_proto_t proto;   // protocol of current write segment
        logic [3:0]          bitcnt;  // 0..7 data bits, 8 ack slot, 15 after start
        logic [7:0]          shift;   // byte on the wire
        logic [3:0]          idx;     // byte index within write segment
        logic [2:0]          tidx;    // byte index within read segment
        logic                rd;      // address byte asked for read
        logic                in_txn;  // between start and stop
        logic                mack;    // master acked last sent byte
        logic [3:0][7:0]     cmd;     // latched command bytes
        logic [31:0]         rdata;   // register value to return
        logic [7:0]          crc;     // running packet error code
        logic                scl_d;   // previous filtered scl
        logic                sda_d;   // previous filtered sda
        logic                oe_n;    // sda released when high
        logic                req;     // config access outstanding
        logic                we;      // access is a write
        logic [4:0]          port;    // access port select
        logic [3:0]          be;      // access byte enables
        logic [9:0]          addr;    // access dword address
        logic [31:0]         wdata;   // collected write data
        logic [31:0]         ctrl;    // slave address control register
        logic [2:0]          boot;    // strap capture delay
        logic                loaded;  // strap address captured
    } sca_state_t;

    sca_state_t s;       // registered state
    sca_state_t next_s;  // next state
    logic       scl;     // filtered scl
    logic       sda;     // filtered sda
    logic [2:0] strap;   // filtered address straps

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    sca_pin_sync #(.W(5)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({scl_in, sda_in, addr_strap}),
        .q      ({scl, sda, strap})
    );

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    // one bit of crc-8
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? sca_pkg::SCA_PEC_POLY : 8'h00);
    endfunction

    // byte returned at a read-segment index
    function automatic logic [7:0] tx_byte(input logic [2:0] t, input sca_state_t st);
        unique case (t)
            3'd0:    return sca_pkg::SCA_BYTE_COUNT;
            3'd1:    return st.rdata[31:24];
            3'd2:    return st.rdata[23:16];
            3'd3:    return st.rdata[15:8];
            3'd4:    return st.rdata[7:0];
            3'd5:    return st.crc;
            default: return sca_pkg::SCA_IDLE_BYTE;
        endcase
    endfunction

    // command byte fields
    logic [4:0] c_port;   // five-bit port select
    logic [9:0] c_addr;   // dword address
    logic       c_ok;     // port in range
    logic       c_self;   // targets the control register
    assign c_port = {s.cmd[1][3:0], s.cmd[2][7]};
    assign c_addr = {s.cmd[2][1:0], s.cmd[3]};
    assign c_ok   = (c_port <= sca_pkg::SCA_PORT_MAX);
    assign c_self = (c_port == sca_pkg::SCA_CTRL_PORT) && (c_addr == sca_pkg::SCA_CTRL_DWORD);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic       start;
        logic       stop;
        logic       rise;
        logic       fall;
        logic       smb;
        logic [3:0] k;
        logic [7:0] b;
        logic [7:0] nb;
        next_s = s;
        start  = scl && s.scl_d && s.sda_d && !sda;
        stop   = scl && s.scl_d && !s.sda_d && sda;
        rise   = scl && !s.scl_d;
        fall   = !scl && s.scl_d;
        smb    = (s.proto != sca_pkg::SCA_P_I2C);
        k      = smb ? 4'(s.idx - 4'(sca_pkg::SCA_SMB_CMD_IDX))
                     : 4'(s.idx - 4'(sca_pkg::SCA_I2C_CMD_IDX));
        b      = s.shift;
        nb     = 8'h00;
        next_s.scl_d = scl;
        next_s.sda_d = sda;
        // config access completion, served whatever the link does
        if (s.req && cfg_ack) begin
            next_s.req = 1'b0;
            if (!s.we) begin
                next_s.rdata = cfg_rdata;
            end
        end
        // strap address capture after reset release
        if (!s.loaded) begin
            next_s.boot = s.boot + 3'd1;
            if (s.boot == sca_pkg::SCA_BOOT_CYCLES) begin
                next_s.ctrl[7:1] = {sca_pkg::SCA_ADDR_HIGH, strap};
                next_s.loaded    = 1'b1;
            end
        end
        if (start) begin
            // start or repeated start, pec spans the whole transaction
            if (!s.in_txn) begin
                next_s.crc = sca_pkg::SCA_PEC_INIT;
            end
            next_s.in_txn = 1'b1;
            next_s.mode   = sca_pkg::SCA_RX;
            next_s.bitcnt = 4'hF;   // scl fall that closes the start is not a bit
            next_s.idx    = 4'd0;
            next_s.rd     = 1'b0;
            next_s.oe_n   = 1'b1;
        end else if (stop) begin
            next_s.in_txn = 1'b0;
            next_s.mode   = sca_pkg::SCA_IDLE;
            next_s.oe_n   = 1'b1;
        end else if (s.mode != sca_pkg::SCA_IDLE) begin
            // sample bits on rising scl
            if (rise) begin
                if (s.bitcnt < 4'd8) begin
                    next_s.shift = {s.shift[6:0], sda};
                end else if (s.mode == sca_pkg::SCA_TX) begin
                    next_s.mack = !sda;
                end
            end
            // drive sda on falling scl
            if (fall) begin
                if (s.bitcnt == 4'd7) begin
                    next_s.bitcnt = 4'd8;
                    // pec over whole bytes only, so a half slot before sr is not counted
                    for (int j = 7; j >= 0; j--) begin
                        next_s.crc = crc_step(next_s.crc, s.shift[j]);
                    end
                    next_s.oe_n   = 1'b1;
                    if (s.mode == sca_pkg::SCA_RX) begin
                        next_s.idx = (s.idx == 4'hF) ? s.idx : 4'(s.idx + 4'd1);
                        if (s.idx == 4'd0) begin
                            // address byte against control field
                            if (b[7:1] == s.ctrl[7:1]) begin
                                next_s.oe_n = 1'b0;
                                next_s.rd   = b[0];
                                next_s.tidx = 3'd0;
                                if (b[0]) begin
                                    // fetch register for the read
                                    if (s.cmd[0][2:0] != sca_pkg::SCA_CMD_READ || !c_ok) begin
                                        next_s.rdata = 32'h0000_0000;
                                    end else if (c_self) begin
                                        next_s.rdata = s.ctrl;
                                    end else begin
                                        next_s.req  = 1'b1;
                                        next_s.we   = 1'b0;
                                        next_s.port = c_port;
                                        next_s.be   = s.cmd[2][5:2];
                                        next_s.addr = c_addr;
                                    end
                                end
                            end else begin
                                next_s.mode = sca_pkg::SCA_IDLE;
                            end
                        end else if (s.idx == 4'd1) begin
                            // first byte picks smbus code or i2c command
                            next_s.oe_n = 1'b0;
                            unique case (b)
                                sca_pkg::SCA_CODE_SETUP: next_s.proto = sca_pkg::SCA_P_SETUP;
                                sca_pkg::SCA_CODE_BREAD: next_s.proto = sca_pkg::SCA_P_BREAD;
                                sca_pkg::SCA_CODE_CALL:  next_s.proto = sca_pkg::SCA_P_CALL;
                                default: begin
                                    next_s.proto  = sca_pkg::SCA_P_I2C;
                                    next_s.cmd[0] = b;
                                end
                            endcase
                        end else if (smb || s.idx <= 4'(sca_pkg::SCA_I2C_LAST)) begin
                            next_s.oe_n = 1'b0;
                            if (k < 4'd4) begin
                                next_s.cmd[k[1:0]] = b;
                            end else if (!smb) begin
                                next_s.wdata = {s.wdata[23:0], b};
                                if (s.idx == 4'(sca_pkg::SCA_I2C_LAST)) begin
                                    // commit only a valid write
                                    if (s.cmd[0][2:0] == sca_pkg::SCA_CMD_WRITE && c_ok) begin
                                        if (c_self) begin
                                            for (int j = 0; j < 4; j++) begin
                                                if (s.cmd[2][2+j]) begin
                                                    next_s.ctrl[8*j +: 8] =
                                                        next_s.wdata[8*j +: 8];
                                                end
                                            end
                                        end else begin
                                            next_s.req  = 1'b1;
                                            next_s.we   = 1'b1;
                                            next_s.port = c_port;
                                            next_s.be   = s.cmd[2][5:2];
                                            next_s.addr = c_addr;
                                        end
                                    end
                                end
                            end
                        end
                        // in plain i2c, bytes past the fourth data byte stay released
                    end
                end else if (s.bitcnt == 4'd8) begin
                    next_s.bitcnt = 4'd0;
                    next_s.oe_n   = 1'b1;
                    if (s.mode == sca_pkg::SCA_RX && s.rd) begin
                        nb            = tx_byte(3'd0, s);
                        next_s.mode   = sca_pkg::SCA_TX;
                        next_s.shift  = nb;
                        next_s.oe_n   = nb[7];
                    end else if (s.mode == sca_pkg::SCA_TX) begin
                        if (s.mack) begin
                            next_s.tidx  = (s.tidx == 3'd7) ? s.tidx : 3'(s.tidx + 3'd1);
                            nb           = tx_byte(next_s.tidx, s);
                            next_s.shift = nb;
                            next_s.oe_n  = nb[7];
                        end else begin
                            next_s.mode = sca_pkg::SCA_IDLE;
                        end
                    end
                end else begin
                    next_s.bitcnt = 4'(s.bitcnt + 4'd1);
                    if (s.mode == sca_pkg::SCA_TX) begin
                        next_s.oe_n = s.shift[7];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s        <= '0;
            s.mode   <= sca_pkg::SCA_IDLE;
            s.proto  <= sca_pkg::SCA_P_I2C;
            s.oe_n   <= 1'b1;
            s.crc    <= sca_pkg::SCA_PEC_INIT;
            s.ctrl   <= sca_pkg::SCA_CTRL_RESET;
            s.scl_d  <= 1'b0;
            s.sda_d  <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, scl is never stretched
    assign scl_out   = 1'b0;
    assign scl_oe_n  = 1'b1;
    assign sda_out   = 1'b0;
    assign sda_oe_n  = s.oe_n;
    assign cfg_req   = s.req;
    assign cfg_we    = s.we;
    assign cfg_port  = s.port;
    assign cfg_be    = s.be;
    assign cfg_addr  = s.addr;
    assign cfg_wdata = s.wdata;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence seq_ack_slot;
        s.mode == sca_pkg::SCA_RX && s.bitcnt == 4'd7 && !scl && s.scl_d;
    endsequence

    a_port_in_range: assert property (cfg_req |-> cfg_port <= sca_pkg::SCA_PORT_MAX)
        else $error("config access with port above five");
    a_write_valid_cmd: assert property ($rose(cfg_req) && cfg_we |->
            $past(s.cmd[0][2:0]) == sca_pkg::SCA_CMD_WRITE)
        else $error("write issued without write command");
    a_read_valid_cmd: assert property ($rose(cfg_req) && !cfg_we |->
            $past(s.cmd[0][2:0]) == sca_pkg::SCA_CMD_READ)
        else $error("read issued without read command");
    a_addr_fields: assert property ($rose(cfg_req) |->
            cfg_addr == {s.cmd[2][1:0], s.cmd[3]} && cfg_be == s.cmd[2][5:2])
        else $error("address or enables do not match command bytes");
    a_extra_nak: assert property (seq_ack_slot ##0 (s.proto == sca_pkg::SCA_P_I2C &&
            s.idx > 4'(sca_pkg::SCA_I2C_LAST)) |=> sda_oe_n)
        else $error("extra data byte acknowledged");
    a_count_first: assert property (s.mode == sca_pkg::SCA_RX && $past(s.mode) ==
            sca_pkg::SCA_RX ##1 s.mode == sca_pkg::SCA_TX |-> s.shift == 8'h04)
        else $error("read segment did not open with byte count");
    a_strap_addr: assert property ($rose(s.loaded) |->
            s.ctrl[7:1] == {sca_pkg::SCA_ADDR_HIGH, $past(strap)})
        else $error("default address not formed from straps");
    a_addr_match_ack: assert property (seq_ack_slot ##0 (s.idx == 4'd0 &&
            s.shift[7:1] == s.ctrl[7:1]) |=> !sda_oe_n)
        else $error("own address not acknowledged");

endmodule

/* bench/sca_master.sv */
// Purpose: bus master model driving scl and sda of the slave
// Assumes: open drain lines, 1 here means released to the pull-up
// Notes: scl period is 32 core clocks; crc covers every byte on the bus
`timescale 1ns/10ps
module sca_master (
    input  wire logic clk,
    input  wire logic sda_bus,
    output logic      scl,
    output logic      sda
);
    logic [7:0] crc; // running packet error code, cleared by the bench
    // idle bus: both lines released
    initial {scl, sda, crc} = 10'h3FF;
    ////////////////////////////////////////////////////////////
    // set both lines, then wait a quarter period on falling edges
    task automatic lv(input logic s, input logic c);
        sda = s;
        scl = c;
        repeat (8) @(negedge clk);
    endtask
    // one bit slot, line sampled while scl is high
    task automatic slot(input logic b, output logic r);
        lv(b, 1'b0);
        lv(b, 1'b1);
        r = sda_bus;
        lv(b, 1'b1);
        lv(b, 1'b0);
    endtask
    // start or repeated start: sda falls under high scl
    task automatic start();
        lv(1'b1, 1'b0);
        lv(1'b1, 1'b1);
        lv(1'b0, 1'b1);
        lv(1'b0, 1'b0);
    endtask
    // stop: sda rises under high scl
    task automatic stop();
        lv(1'b0, 1'b0);
        lv(1'b0, 1'b1);
        lv(1'b1, 1'b1);
    endtask
    // crc-8 with polynomial 07h, msb first
    task automatic acc(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ b[i]) ? 8'h07 : 8'h00);
    endtask
    // send a byte msb first, return the slave's ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) slot(d[i], r);
        slot(1'b1, r);
        ack = !r;
        acc(d);
    endtask
    // take a byte, nak it when it is the last
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
        slot(last, r);
        acc(d);
    endtask
endmodule

/* bench/sideband_cfg_access_slave_test.sv */
// Purpose: self-checking bench of the sideband slave
// Assumes: straps 010b, so default write address byte D4h
// Notes: register file model acks each request one cycle later
`timescale 1ns/10ps
module sideband_cfg_access_slave_test;
    typedef struct packed {logic [31:0] cmd; logic [31:0] dat; logic [18:0] exp;} sca_row_t;
    logic        clk, resetn, m_scl, m_sda, scl_out, scl_oe_n, sda_out, sda_oe_n, cfg_req;
    logic        cfg_we, cfg_ack, a;
    logic [2:0]  addr_strap;
    logic [4:0]  cfg_port;
    logic [3:0]  cfg_be;
    logic [9:0]  cfg_addr;
    logic [31:0] cfg_wdata;
    logic [51:0] last_req; // we, port, be, addr, wdata of the last request
    logic [7:0]  d;
    int          bad_count = 0, checked = 0, reqs = 0, cycles = 0, n;
    wire logic        sda_w     = m_sda & (sda_oe_n | sda_out); // wired and, pulled up
    wire logic        scl_w     = m_scl & (scl_oe_n | scl_out);
    wire logic [31:0] cfg_rdata = {16'hC0DE, 6'h00, cfg_addr}; // pattern per address
    // writes: plain, port 5 with partial enables, single enable
    sca_row_t rows [3] = '{'{32'h0300_3C3E, 32'h1234_5678, {5'h00, 4'hF, 10'h03E}},
        '{32'h0302_A7FF, 32'hA5C3_0F96, {5'h05, 4'h9, 10'h3FF}},
        '{32'h0301_8400, 32'hDEAD_BEEF, {5'h03, 4'h1, 10'h000}}};
    sca_master m (.clk(clk), .sda_bus(sda_w), .scl(m_scl), .sda(m_sda));
    sca_slave uut (.clk(clk), .resetn(resetn), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_strap(addr_strap), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_port(cfg_port),
        .cfg_be(cfg_be), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    // register file: one-cycle ack, request logged
    always @(negedge clk) begin
        cfg_ack <= cfg_req && !cfg_ack;
        if (cfg_req && !cfg_ack) begin
            reqs <= reqs + 1;
            last_req <= {cfg_we, cfg_port, cfg_be, cfg_addr, cfg_wdata};
        end
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic check(input logic ok, input string msg);
        checked++;
        if (!ok) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic put(input logic [7:0] b, input logic ack);
        m.wbyte(b, a);
        check(a === ack, "ack");
    endtask
    task automatic get(input logic last, input logic [7:0] exp);
        m.rbyte(last, d);
        check(d === exp, "read byte");
    endtask
    // start, address, then nb bytes from the top of b
    task automatic pkt(input logic [7:0] adr, input logic [63:0] b, input int nb);
        m.start();
        put(adr, 1'b1);
        for (int i = 0; i < nb; i++) put(b[63-8*i -: 8], 1'b1);
    endtask
    // smbus read of port 1 dword 03Eh, split or process call
    task automatic smb_read(input logic [7:0] code);
        m.crc = 8'h00;
        pkt(8'hD4, {code, 40'h04_0400_BC3E, 16'h0000}, 6);
        if (code == 8'hBA) begin
            m.stop();
            pkt(8'hD4, {8'hBD, 56'h0}, 1);
        end
        m.start();
        put(8'hD5, 1'b1);
        get(1'b0, 8'h04);
        get(1'b0, 8'hC0);
        get(1'b0, 8'hDE);
        get(1'b0, 8'h00);
        get(code == 8'hBA, 8'h3E);
        if (code != 8'hBA) get(1'b1, m.crc);
        m.stop();
        check(last_req[51:32] === {1'b0, 5'h01, 4'hF, 10'h03E}, "read request");
    endtask
    initial begin
        resetn = 1'b0;
        cfg_ack = 1'b0;
        addr_strap = 3'b010;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (12) @(negedge clk);
        check(sda_oe_n === 1'b1 && scl_oe_n === 1'b1 && cfg_req === 1'b0, "idle after reset");
        foreach (rows[i]) begin
            n = reqs;
            pkt(8'hD4, {rows[i].cmd, rows[i].dat}, 8);
            m.stop();
            check(reqs == n + 1 && last_req === {1'b1, rows[i].exp, rows[i].dat}, "write");
        end
        pkt(8'hD4, 64'h0300_3C10_0102_0304, 8);
        put(8'h55, 1'b0);
        m.start();
        put(8'hD0, 1'b0);
        m.stop();
        check(last_req === {1'b1, 5'h00, 4'hF, 10'h010, 32'h0102_0304}, "write");
        n = reqs;
        pkt(8'hD4, 64'h0303_3C00_FFFF_FFFF, 8);
        m.stop();
        pkt(8'hD4, 64'h0700_3C00_FFFF_FFFF, 8);
        m.stop();
        check(reqs == n, "invalid command reached registers");
        smb_read(8'hBA);
        smb_read(8'hCD);
        pkt(8'hD4, 64'h0300_3CD1_0000_00B0, 8);
        m.start();
        put(8'hD4, 1'b0);
        m.start();
        put(8'hB0, 1'b1);
        m.stop();
        // control register read back through the new address
        pkt(8'hB0, 64'hCD04_0400_3CD1_0000, 6);
        m.start();
        put(8'hB1, 1'b1);
        get(1'b0, 8'h04);
        get(1'b0, 8'h00);
        get(1'b0, 8'h00);
        get(1'b0, 8'h00);
        get(1'b1, 8'hB0);
        m.stop();
        // second reset with other straps: address comes back from the pins
        addr_strap = 3'b001;
        resetn = 1'b0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        repeat (12) @(negedge clk);
        check(sda_oe_n === 1'b1 && cfg_req === 1'b0, "idle after second reset");
        pkt(8'hD2, 64'h0, 0);
        m.stop();
        close_out();
    end
endmodule
